/* File: rtl/sitf_pkg.sv */
// shared constants for the safety input stable time filter
package sitf_pkg;
  // port types, fixed parameter sets
  typedef enum logic [1:0] {
    SITF_TYPE_A,
    SITF_TYPE_B,
    SITF_TYPE_C,
    SITF_TYPE_D
  } sitf_type_t;

  // stable time filter states
  typedef enum logic [1:0] {
    SITF_IDLE,
    SITF_MONITOR,
    SITF_ON,
    SITF_FAULT
  } sitf_state_t;

  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned LINK_FIRST = 4;
  localparam int unsigned NUM_LINK = 4;

  // clock rate and times in their own units
  localparam longint unsigned CYC_PER_US = 100;
  localparam longint unsigned STABLE_AB_MS = 100;
  localparam longint unsigned STABLE_CD_MS = 500;
  localparam longint unsigned MON_AB_S = 2;
  localparam longint unsigned MON_CD_S = 10;
  localparam longint unsigned TP_LEN_MS = 1;
  localparam longint unsigned TP_PERIOD_MS = 500;
  localparam longint unsigned TP_SLOT_MS = 2;
  localparam longint unsigned SEMICONDUCTOR_SAFETY_OUTPUT_PULSE_MIN_US = 10;
  localparam longint unsigned SEMICONDUCTOR_SAFETY_OUTPUT_PULSE_MAX_US = 1000;
  localparam longint unsigned SEMICONDUCTOR_SAFETY_OUTPUT_GAP_MIN_MS = 20;
  localparam longint unsigned SEMICONDUCTOR_SAFETY_OUTPUT_GAP_MAX_S = 120;
  localparam longint unsigned BRIDGE_US = 1100;
  localparam longint unsigned LINK_IDLE_MS = 10;

  // derived cycle counts
  localparam logic [31:0] STABLE_AB_CYC = 32'(STABLE_AB_MS * 1000 * CYC_PER_US);
  localparam logic [31:0] STABLE_CD_CYC = 32'(STABLE_CD_MS * 1000 * CYC_PER_US);
  localparam logic [31:0] MON_AB_CYC = 32'(MON_AB_S * 1000000 * CYC_PER_US);
  localparam logic [31:0] MON_CD_CYC = 32'(MON_CD_S * 1000000 * CYC_PER_US);
  localparam logic [31:0] TP_LEN_CYC = 32'(TP_LEN_MS * 1000 * CYC_PER_US);
  localparam logic [31:0] TP_PERIOD_CYC = 32'(TP_PERIOD_MS * 1000 * CYC_PER_US);
  localparam logic [31:0] TP_SLOT_CYC = 32'(TP_SLOT_MS * 1000 * CYC_PER_US);
  localparam logic [35:0] PULSE_MIN_CYC = 36'(SEMICONDUCTOR_SAFETY_OUTPUT_PULSE_MIN_US * CYC_PER_US);
  localparam logic [35:0] PULSE_MAX_CYC = 36'(SEMICONDUCTOR_SAFETY_OUTPUT_PULSE_MAX_US * CYC_PER_US);
  localparam logic [35:0] GAP_MIN_CYC = 36'(SEMICONDUCTOR_SAFETY_OUTPUT_GAP_MIN_MS * 1000 * CYC_PER_US);
  localparam logic [35:0] GAP_MAX_CYC = 36'(SEMICONDUCTOR_SAFETY_OUTPUT_GAP_MAX_S * 1000000 * CYC_PER_US);
  localparam logic [35:0] BRIDGE_CYC = 36'(BRIDGE_US * CYC_PER_US);
  localparam logic [31:0] LINK_IDLE_CYC = 32'(LINK_IDLE_MS * 1000 * CYC_PER_US);
endpackage

/* File: rtl/sitf_channel.sv */
// one safety input: test pulse bridging and switchgear pulse monitoring
`timescale 1ns/1ns
module sitf_channel #(
  parameter logic [35:0] PULSE_MIN = sitf_pkg::PULSE_MIN_CYC,
  parameter logic [35:0] PULSE_MAX = sitf_pkg::PULSE_MAX_CYC,
  parameter logic [35:0] GAP_MIN = sitf_pkg::GAP_MIN_CYC,
  parameter logic [35:0] GAP_MAX = sitf_pkg::GAP_MAX_CYC,
  parameter logic [35:0] BRIDGE = sitf_pkg::BRIDGE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // input and mode
  input wire logic raw,
  input wire logic semiconductor_safety_output_mode,
  // results
  output logic on,
  output logic pulse_fault
);
  logic raw_q;
  logic [35:0] low_cnt;
  logic [35:0] gap_cnt;
  wire rise = raw & ~raw_q;
  wire bridged = raw | (on & (low_cnt < BRIDGE));
  // a short low is a pulse of the switchgear, not a real switch-off
  wire short_pulse = rise & on & (low_cnt < PULSE_MIN);
  wire long_pulse = rise & on & (low_cnt > PULSE_MAX);
  wire close_pulse = rise & on & (gap_cnt < GAP_MIN);
  wire no_pulse = on & raw & (gap_cnt >= GAP_MAX);
  wire bad = semiconductor_safety_output_mode & (short_pulse | long_pulse | close_pulse | no_pulse);

  // low time, gap time and bridged level
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      raw_q <= 1'b0;
      low_cnt <= '0;
      gap_cnt <= '0;
      on <= 1'b0;
    end else begin
      raw_q <= raw;
      low_cnt <= raw ? '0 : (low_cnt == '1 ? low_cnt : low_cnt + 36'h1);
      gap_cnt <= (rise | ~on) ? '0 : (gap_cnt == '1 ? gap_cnt : gap_cnt + 36'h1);
      on <= bridged;
    end
  end

  // fault holds until the input is really off; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pulse_fault <= 1'b0;
    end else begin
      pulse_fault <= bad | (pulse_fault & on);
    end
  end
endmodule

/* File: rtl/sitf_top.sv */
// eight-port safety input evaluation with stable time filters
// Behaviour
// - each of eight ports has two safety inputs and two test pulse outputs.
// - contact ports: outputs high, one 1 ms low pulse every 500 ms.
// - contact inputs are checked for cross faults against every other input.
// - semiconductor ports get constant high supply, no cross-fault checking.
// - semiconductor inputs have their incoming test pulses monitored.
// - each port takes one of four fixed types A, B, C, D.
// - types A, B: two-channel semiconductor, 0.1 s stable, 2 s monitoring.
// - types C, D: 0.5 s stable, 10 s monitoring, one-wire output.
// - cross-fault detection on for C and D, off for A and B.
// - type D evaluates the two inputs as independent single channels.
// - every input is stable-time filtered with times fixed by the type.
// - two-channel: monitoring starts when the first contact switches on.
// - two-channel: on after both stay on for stable time within monitoring.
// - two-channel: fault when monitoring expires unsettled or with one dropout.
// - single-channel: monitoring starts on first on, on after stable time.
// - single-channel: fault when monitoring expires unsettled or after a dropout.
// - release waits only the stable time, never a fixed discrepancy time.
// - each port has a digital output, paired with second wire in type B.
// - diagnostic input per port; four ports detect an attached panel link.
`timescale 1ns/1ns
module sitf_top #(
  parameter logic [31:0] STABLE_AB = sitf_pkg::STABLE_AB_CYC,
  parameter logic [31:0] STABLE_CD = sitf_pkg::STABLE_CD_CYC,
  parameter logic [31:0] MON_AB = sitf_pkg::MON_AB_CYC,
  parameter logic [31:0] MON_CD = sitf_pkg::MON_CD_CYC,
  parameter logic [31:0] TP_LEN = sitf_pkg::TP_LEN_CYC,
  parameter logic [31:0] TP_PERIOD = sitf_pkg::TP_PERIOD_CYC,
  parameter logic [31:0] TP_SLOT = sitf_pkg::TP_SLOT_CYC,
  parameter logic [35:0] PULSE_MIN = sitf_pkg::PULSE_MIN_CYC,
  parameter logic [35:0] PULSE_MAX = sitf_pkg::PULSE_MAX_CYC,
  parameter logic [35:0] GAP_MIN = sitf_pkg::GAP_MIN_CYC,
  parameter logic [35:0] GAP_MAX = sitf_pkg::GAP_MAX_CYC,
  parameter logic [35:0] BRIDGE = sitf_pkg::BRIDGE_CYC,
  parameter logic [31:0] LINK_IDLE = sitf_pkg::LINK_IDLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // configuration, two bits per device_port
  input wire logic [15:0] port_type,
  // safety inputs and test pulse outputs, two per device_port
  input wire logic [15:0] safety_in,
  output logic [15:0] test_pulse_out,
  // filter results
  output logic [15:0] safety_function_on,
  output logic [7:0] stability_fault,
  output logic [7:0] cross_fault,
  output logic [7:0] pulse_fault,
  // safety outputs
  input wire logic [7:0] output_request,
  output logic [7:0] digital_output,
  output logic [7:0] second_wire_output,
  // diagnostic inputs and panel link detection
  input wire logic [7:0] diag_in,
  output logic [7:0] diag_status,
  output logic [3:0] link_present
);
  localparam int unsigned NP = sitf_pkg::NUM_PORTS;
  localparam int unsigned NC = sitf_pkg::NUM_CH;

  logic [31:0] tp_cnt;
  logic [15:0] snap;
  logic [15:0] ch_on;
  logic [15:0] ch_pfault;
  logic [15:0] contact_mask;
  logic [15:0] semiconductor_safety_output_mask;
  logic [15:0] pair_mask;
  logic [15:0] slot_low;
  logic [15:0] slot_start;
  logic [15:0] slot_end;
  logic [15:0] unit_fault;
  logic diag_primed;
  logic [7:0] type_b;

  // shared test pulse time base
  wire tp_wrap = (tp_cnt == TP_PERIOD - 32'h1);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tp_cnt <= '0;
    end else begin
      tp_cnt <= tp_wrap ? '0 : tp_cnt + 32'h1;
    end
  end

  // per-port type decode and per-channel masks
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      wire sitf_pkg::sitf_type_t ptype = sitf_pkg::sitf_type_t'(port_type[2*p +: 2]);
      wire is_contact = (ptype == sitf_pkg::SITF_TYPE_C) | (ptype == sitf_pkg::SITF_TYPE_D);
      assign contact_mask[2*p +: 2] = {2{is_contact}};
      assign semiconductor_safety_output_mask[2*p +: 2] = {2{~is_contact}};
      assign pair_mask[2*p +: 2] = {2{ptype != sitf_pkg::SITF_TYPE_D}};
      assign type_b[p] = (ptype == sitf_pkg::SITF_TYPE_B);
    end
  endgenerate

  // staggered slots, so a short between two inputs shows in the wrong one
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_slot
      localparam logic [31:0] OFS = 32'(c) * TP_SLOT;
      assign slot_start[c] = (tp_cnt == OFS);
      assign slot_end[c] = (tp_cnt == OFS + TP_LEN - 32'h1);
      assign slot_low[c] = (tp_cnt >= OFS) & (tp_cnt < OFS + TP_LEN);
    end
  endgenerate

  // semiconductor ports get a constant supply, contacts get pulses
  wire [15:0] next_tp_out = ~(slot_low & contact_mask);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      test_pulse_out <= '1;
    end else begin
      test_pulse_out <= next_tp_out;
    end
  end

  // cross-fault check at the last cycle of each slot
  wire any_start = |slot_start;
  wire any_end = |slot_end;
  wire [15:0] dropped = snap & ~safety_in;
  wire [15:0] stuck = snap & safety_in;
  wire [15:0] xf_hit = any_end ?
      (((dropped & ~slot_end) | (stuck & slot_end)) & contact_mask) : '0;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      snap <= '0;
    end else if (any_start) begin
      snap <= safety_in;
    end
  end

  // per-channel pulse bridging and semiconductor pulse check
  generate
    for (c = 0; c < NC; c++) begin : g_ch
      sitf_channel #(
        .PULSE_MIN(PULSE_MIN),
        .PULSE_MAX(PULSE_MAX),
        .GAP_MIN(GAP_MIN),
        .GAP_MAX(GAP_MAX),
        .BRIDGE(BRIDGE)
      ) u_ch (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .raw(safety_in[c]),
        .semiconductor_safety_output_mode(semiconductor_safety_output_mask[c]),
        .on(ch_on[c]),
        .pulse_fault(ch_pfault[c])
      );
    end
  endgenerate

  // stable time filter units; odd unit runs only for single-channel ports
  generate
    for (c = 0; c < NC; c++) begin : g_unit
      localparam int unsigned PRT = c / 2;
      localparam bit ODD = (c % 2) == 1;
      sitf_pkg::sitf_state_t state;
      sitf_pkg::sitf_state_t next_state;
      logic [31:0] mon_cnt;
      logic [31:0] stab_cnt;
      wire pair = pair_mask[c];
      wire ab = semiconductor_safety_output_mask[c];
      wire blocked = cross_fault[PRT] | pulse_fault[PRT];
      wire [1:0] pins = ch_on[2*PRT +: 2];
      wire active = ~(ODD & pair);
      // pair needs both inputs, a single channel its own
      wire all_on = active & ~blocked & (pair ? &pins : ch_on[c]);
      wire any_on = active & (pair ? |pins : ch_on[c]);
      wire [31:0] stable_lim = ab ? STABLE_AB : STABLE_CD;
      wire [31:0] mon_lim = ab ? MON_AB : MON_CD;
      wire settled = all_on & (stab_cnt == stable_lim - 32'h1);
      wire expired = (mon_cnt == mon_lim - 32'h1);

      // state changes; settling wins over expiry in the same cycle
      always_comb begin
        next_state = state;
        case (state)
          sitf_pkg::SITF_IDLE: begin
            if (any_on) begin
              next_state = sitf_pkg::SITF_MONITOR;
            end
          end
          sitf_pkg::SITF_MONITOR: begin
            if (settled) begin
              next_state = sitf_pkg::SITF_ON;
            end else if (expired) begin
              next_state = sitf_pkg::SITF_FAULT;
            end
          end
          sitf_pkg::SITF_ON: begin
            if (!all_on) begin
              next_state = sitf_pkg::SITF_IDLE;
            end
          end
          sitf_pkg::SITF_FAULT: begin
            if (!any_on) begin
              next_state = sitf_pkg::SITF_IDLE;
            end
          end
          default: begin
            next_state = sitf_pkg::SITF_IDLE;
          end
        endcase
      end

      // monitoring runs on through dropouts; stable count restarts on any
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          state <= sitf_pkg::SITF_IDLE;
          mon_cnt <= '0;
          stab_cnt <= '0;
        end else begin
          state <= next_state;
          if (state == sitf_pkg::SITF_MONITOR) begin
            mon_cnt <= mon_cnt + 32'h1;
            stab_cnt <= all_on ? stab_cnt + 32'h1 : '0;
          end else begin
            mon_cnt <= '0;
            stab_cnt <= '0;
          end
        end
      end

      assign unit_fault[c] = (state == sitf_pkg::SITF_FAULT);
      assign safety_function_on[c] = (state == sitf_pkg::SITF_ON);
    end
  endgenerate

  // port faults; cross and pulse faults are held until the port inputs are all off
  generate
    for (p = 0; p < NP; p++) begin : g_flt
      wire port_off = ~|ch_on[2*p +: 2];
      wire xf_set = |xf_hit[2*p +: 2];
      wire pf_set = |ch_pfault[2*p +: 2];
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          cross_fault[p] <= 1'b0;
          pulse_fault[p] <= 1'b0;
        end else begin
          cross_fault[p] <= xf_set | (cross_fault[p] & ~port_off);
          pulse_fault[p] <= pf_set | (pulse_fault[p] & ~port_off);
        end
      end
      assign stability_fault[p] = |unit_fault[2*p +: 2];
    end
  endgenerate

  // safety outputs; second wire follows only in two-wire type
  wire [7:0] next_dout = output_request;
  wire [7:0] next_second = output_request & type_b;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      digital_output <= '0;
      second_wire_output <= '0;
      diag_status <= '0;
    end else begin
      digital_output <= next_dout;
      second_wire_output <= next_second;
      diag_status <= diag_in;
    end
  end

  // panel link presence: activity on the diagnostic line keeps it alive
  genvar k;
  generate
    for (k = 0; k < sitf_pkg::NUM_LINK; k++) begin : g_link
      localparam int unsigned DP = sitf_pkg::LINK_FIRST + k;
      logic [31:0] idle_cnt;
      wire edge_seen = diag_primed & (diag_in[DP] ^ diag_status[DP]);
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          idle_cnt <= '0;
          link_present[k] <= 1'b0;
        end else if (edge_seen) begin
          idle_cnt <= '0;
          link_present[k] <= 1'b1;
        end else if (idle_cnt == LINK_IDLE - 32'h1) begin
          link_present[k] <= 1'b0;
        end else begin
          idle_cnt <= idle_cnt + 32'h1;
        end
      end
    end
  endgenerate

  // first sample after reset only loads the copy; a high idle line is no edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      diag_primed <= 1'b0;
    end else begin
      diag_primed <= 1'b1;
    end
  end
endmodule

/* File: verification/sitf_chk.sv */
// assertion checker for the safety input stable time filter ports
`timescale 1ns/1ns
module sitf_chk #(
  parameter logic [31:0] STABLE_CD = sitf_pkg::STABLE_CD_CYC,
  parameter logic [31:0] MON_CD = sitf_pkg::MON_CD_CYC,
  parameter logic [31:0] TP_LEN = sitf_pkg::TP_LEN_CYC,
  parameter logic [31:0] TP_PERIOD = sitf_pkg::TP_PERIOD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // inputs of the block
  input wire logic [15:0] port_type,
  input wire logic [15:0] safety_in,
  input wire logic [7:0] output_request,
  input wire logic [7:0] diag_in,
  // outputs of the block
  input wire logic [15:0] test_pulse_out,
  input wire logic [15:0] safety_function_on,
  input wire logic [7:0] stability_fault,
  input wire logic [7:0] cross_fault,
  input wire logic [7:0] digital_output,
  input wire logic [7:0] second_wire_output,
  input wire logic [3:0] link_present
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] lo_cnt, hi_cnt, up_cnt, mon_cnt;
  logic armed;
  logic [7:0] is_b;
  logic [15:0] ab_pair;
  // type decode: bit 1 clear means a semiconductor port
  for (genvar p = 0; p < 8; p++) begin : g_dec
    assign is_b[p] = port_type[2*p+1 -: 2] == 2'h1;
    assign ab_pair[2*p+1 -: 2] = {2{!port_type[2*p+1]}};
  end
  // run lengths; own test pulse lows do not break a settled input
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lo_cnt <= 32'h0;
      hi_cnt <= 32'h0;
      up_cnt <= 32'h0;
      mon_cnt <= 32'h0;
      armed <= 1'b0;
    end else begin
      lo_cnt <= test_pulse_out[0] ? 32'h0 : lo_cnt + 32'h1;
      hi_cnt <= test_pulse_out[0] ? hi_cnt + 32'h1 : 32'h0;
      armed <= armed | (test_pulse_out[0] & (lo_cnt != 32'h0));
      up_cnt <= (&safety_in[1:0] || test_pulse_out[1:0] != 2'h3) ? up_cnt + 32'h1 : 32'h0;
      mon_cnt <= (!(|safety_in[3:2]) && test_pulse_out[3:2] == 2'h3) ? 32'h0 : mon_cnt + 32'h1;
    end
  end
  a_tp_length: assert property ($rose(test_pulse_out[0]) |-> lo_cnt == TP_LEN)
    else $error("test pulse low time wrong");
  a_tp_period: assert property ($fell(test_pulse_out[0]) && armed |->
    hi_cnt == TP_PERIOD - TP_LEN) else $error("test pulse interval wrong");
  a_ab_steady: assert property ($past(rstn) && $stable(port_type) |->
    (test_pulse_out & ab_pair) == ab_pair) else $error("pulse on semiconductor port");
  a_off_clears: assert property ((!safety_in[0]) [*8] |-> ##[1:4] !safety_function_on[0])
    else $error("function stays on after input off");
  a_stable_first: assert property ($rose(safety_function_on[0]) |-> up_cnt >= STABLE_CD)
    else $error("function on before stable time");
  a_disc_time: assert property ($rose(stability_fault[1]) |->
    mon_cnt >= MON_CD && mon_cnt <= MON_CD + 32'h8) else $error("fault not at monitoring end");
  a_cross_hold: assert property ($fell(cross_fault[4]) |-> $past(safety_in[9:8]) == 2'h0)
    else $error("cross fault cleared with inputs on");
  a_ab_no_cross: assert property ($rose(cross_fault[3]) |-> $past(port_type[7]))
    else $error("cross fault on semiconductor port");
  a_dout_copy: assert property ($past(rstn) |-> digital_output == $past(output_request))
    else $error("digital output not following request");
  a_wire_pair: assert property ($past(rstn) |->
    second_wire_output == ($past(output_request) & $past(is_b))) else $error("second wire wrong");
  a_link_seen: assert property ($changed(diag_in[4]) |-> ##[1:3] link_present[0])
    else $error("link activity not detected");
endmodule

bind sitf_top sitf_chk #(.STABLE_CD(STABLE_CD), .MON_CD(MON_CD), .TP_LEN(TP_LEN),
  .TP_PERIOD(TP_PERIOD)) u_chk (.ref_clk(ref_clk), .rstn(rstn), .port_type(port_type),
  .safety_in(safety_in), .output_request(output_request), .diag_in(diag_in),
  .test_pulse_out(test_pulse_out), .safety_function_on(safety_function_on),
  .stability_fault(stability_fault), .cross_fault(cross_fault),
  .digital_output(digital_output), .second_wire_output(second_wire_output),
  .link_present(link_present));

/* File: verification/sitf_switch_model.sv */
// switch and sensor model driving the safety inputs
`timescale 1ns/1ns
module sitf_switch_model (
  // clock
  input wire logic ref_clk,
  // switch states set by the bench
  input wire logic [15:0] closed,
  input wire logic [15:0] semiconductor_safety_output_on,
  input wire logic bad_pulse,
  input wire logic short9,
  // device side
  input wire logic [15:0] test_pulse_out,
  output logic [15:0] safety_in
);
  logic [4:0] pcnt = 5'h00;
  logic pulse_low;
  logic [15:0] feed;
  // sensor self test: 4 low in 30, 7 low when faulty, still bridged
  always @(posedge ref_clk) pcnt <= #1 (pcnt == 5'h1D) ? 5'h00 : pcnt + 5'h01;
  assign pulse_low = pcnt < (bad_pulse ? 5'h07 : 5'h04);
  // dry contacts take their supply line, the neighbour's one when shorted
  assign feed = short9 ? {test_pulse_out[15:10], test_pulse_out[8], test_pulse_out[8:0]} :
    test_pulse_out;
  assign #1 safety_in = (closed & feed) | (semiconductor_safety_output_on & {16{!pulse_low}});
endmodule

/* File: verification/test_safety_input_stable_time_filter.sv */
// self-checking bench for the safety input stable time filter
`timescale 1ns/1ns
module test_safety_input_stable_time_filter;
  localparam logic [31:0] SCD = 32'h28;
  localparam logic [31:0] MCD = 32'h190;
  localparam logic [31:0] SAB = 32'h14;
  localparam logic [31:0] MAB = 32'hC8;
  localparam logic [31:0] TPL = 32'h4;
  localparam logic [31:0] TPP = 32'hC8;
  localparam logic [31:0] TPS = 32'h8;
  localparam logic [31:0] LIDLE = 32'h32;
  localparam logic [35:0] PMIN = 36'h2;
  localparam logic [35:0] PMAX = 36'h6;
  localparam logic [35:0] GMIN = 36'hA;
  localparam logic [35:0] GMAX = 36'h64;
  localparam logic [35:0] BRG = 36'h8;
  logic ref_clk, rstn, bad_pulse, short9;
  logic [15:0] port_type, safety_in, test_pulse_out, safety_function_on, closed, semiconductor_safety_output_on;
  logic [7:0] stability_fault, cross_fault, pulse_fault, output_request;
  logic [7:0] digital_output, second_wire_output, diag_in, diag_status;
  logic [3:0] link_present;
  logic [7:0] req_tbl [3] = '{8'hFF, 8'hA5, 8'h5A};
  int error_cnt, samples_checked, n, i;
  sitf_top #(.STABLE_AB(SAB), .STABLE_CD(SCD), .MON_AB(MAB), .MON_CD(MCD),
    .TP_LEN(TPL), .TP_PERIOD(TPP), .TP_SLOT(TPS), .PULSE_MIN(PMIN),
    .PULSE_MAX(PMAX), .GAP_MIN(GMIN), .GAP_MAX(GMAX), .BRIDGE(BRG),
    .LINK_IDLE(LIDLE)) DUT (.ref_clk(ref_clk), .rstn(rstn), .port_type(port_type),
    .safety_in(safety_in), .test_pulse_out(test_pulse_out),
    .safety_function_on(safety_function_on), .stability_fault(stability_fault),
    .cross_fault(cross_fault), .pulse_fault(pulse_fault), .output_request(output_request),
    .digital_output(digital_output), .second_wire_output(second_wire_output),
    .diag_in(diag_in), .diag_status(diag_status), .link_present(link_present));
  sitf_switch_model u_sw (.ref_clk(ref_clk), .closed(closed), .semiconductor_safety_output_on(semiconductor_safety_output_on),
    .bad_pulse(bad_pulse), .short9(short9), .test_pulse_out(test_pulse_out),
    .safety_in(safety_in));
  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // cycles until a function bit comes on, bounded
  task automatic wait_on(input int b, output int c);
    c = 0;
    while (safety_function_on[b] !== 1'b1 && c < 600) begin
      tick(1);
      c++;
    end
    if (c >= 600) begin
      check("wait on", 32'h0, 32'h1);
      summarize();
    end
  endtask
  // contacts open only after the last slot, so no cross check sees it
  task automatic sync_quiet();
    n = 0;
    while (test_pulse_out[15] !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    while (test_pulse_out[15] !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    if (n >= 500) begin
      check("wait quiet", 32'h0, 32'h1);
      summarize();
    end
  endtask
  // ports 0..7 are C C D A C B A D
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rstn = 1'b0;
    port_type = 16'hC63A;
    closed = 16'h0000;
    semiconductor_safety_output_on = 16'h0000;
    bad_pulse = 1'b0;
    short9 = 1'b0;
    output_request = 8'h00;
    diag_in = 8'h00;
    tick(6);
    check("reset pulses", test_pulse_out, 32'hFFFF);
    check("reset state", {stability_fault, safety_function_on}, 32'h0);
    rstn = 1'b1;
    tick(10);
    sync_quiet();
    while (test_pulse_out[0] !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    i = 0;
    n = 0;
    for (int k = 0; k < 200; k++) begin
      i += !test_pulse_out[0];
      n += (test_pulse_out[13:6] & 8'hF3) != 8'hF3;
      tick(1);
    end
    check("pulse low", i, 32'h4);
    check("pulse period", test_pulse_out[0], 32'h0);
    check("no pulse ab", n, 32'h0);
    $display("test pulse test done");
    sync_quiet();
    closed[1:0] = 2'b11;
    wait_on(0, n);
    check("c release", n >= SCD && n <= SCD + 4, 32'h1);
    check("c pair", {stability_fault[0], safety_function_on[1]}, 32'h0);
    tick(90);
    sync_quiet();
    closed[1] = 1'b0;
    tick(12);
    check("c drop", safety_function_on[0], 32'h0);
    tick(90);
    closed[1] = 1'b1;
    wait_on(0, n);
    check("c rearm", n >= SCD, 32'h1);
    sync_quiet();
    closed = 16'h0000;
    tick(90);
    $display("two channel test done");
    closed[2] = 1'b1;
    closed[4] = 1'b1;
    wait_on(4, n);
    check("d single", n >= SCD && n <= SCD + 4, 32'h1);
    check("d other", safety_function_on[5], 32'h0);
    tick(MCD - 50);
    check("disc early", stability_fault, 32'h0);
    tick(14);
    check("disc fault", {stability_fault, safety_function_on[2]}, 32'h4);
    sync_quiet();
    closed = 16'h0000;
    tick(90);
    check("disc clear", stability_fault, 32'h0);
    $display("discrepancy test done");
    semiconductor_safety_output_on[7:6] = 2'b11;
    wait_on(6, n);
    check("semiconductor_safety_output release", n >= 32'h14 && n <= 32'h1C, 32'h1);
    tick(150);
    check("semiconductor_safety_output steady", {pulse_fault[3], safety_function_on[6]}, 32'h1);
    bad_pulse = 1'b1;
    tick(40);
    check("semiconductor_safety_output bad", {pulse_fault[3], safety_function_on[6]}, 32'h2);
    semiconductor_safety_output_on = 16'h0000;
    bad_pulse = 1'b0;
    tick(90);
    check("semiconductor_safety_output clear", pulse_fault, 32'h0);
    $display("semiconductor test done");
    short9 = 1'b1;
    closed[9:8] = 2'b11;
    tick(420);
    check("cross short", {cross_fault, safety_function_on[8]}, 32'h20);
    sync_quiet();
    closed = 16'h0000;
    short9 = 1'b0;
    tick(90);
    check("cross clear", cross_fault, 32'h0);
    $display("cross fault test done");
    for (int k = 0; k < 3; k++) begin
      output_request = req_tbl[k];
      tick(1);
      check("dout", digital_output, req_tbl[k]);
      check("second wire", second_wire_output, req_tbl[k] & 8'h20);
    end
    diag_in = 8'h11;
    tick(3);
    check("diag copy", diag_status, 32'h11);
    check("link seen", link_present, 32'h1);
    tick(60);
    check("link idle", link_present, 32'h0);
    rstn = 1'b0;
    tick(2);
    check("second reset", {digital_output, link_present}, 32'h0);
    $display("output and link test done");
    summarize();
  end
endmodule
